// file: hw/smf_monitor.sv
// Fault latch and mode configuration of an 18-channel signal monitor.
// Operation
// - Eighteen channels, each with its own green, yellow and red input.
// - Missing card triggers; leaves only when card back and reset given.
// - Conflict records active channels; other faults record failing ones.
// - Recorded faults and channel status hold until a reset.
// - Drive ten status lamps and 54 channel lamps.
// - Red-fail time is 1350 ms when switch on, 850 ms when off.
// - Watchdog time is 1.0 s when switch on, 1.5 s when off.
// - Brown-out time is 400 ms when selected, 80 ms otherwise.
// - Latch off: a power event clears a pending watchdog fault.
// - Latch on: watchdog fault stays until a reset command.
// - Polarity jumper inverts the active sense of relay common.
// - Config fault clears only by front reset held three seconds.
`default_nettype none
module smf_monitor #(
	parameter int MS_CYCLES = smf_pkg::MS_CYCLES,
	parameter int NCH = smf_pkg::NCH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NCH-1:0] green_in,
	input wire logic [NCH-1:0] yellow_in,
	input wire logic [NCH-1:0] red_in,
	input wire logic red_enable,
	input wire logic output_relay_common,
	input wire logic conflict_in,
	input wire logic clearance_in,
	input wire logic dc_supply_fail,
	input wire logic diag_fail,
	input wire logic card_present,
	input wire logic watchdog_timer,
	input wire logic ac_low,
	input wire logic red_fail_time_sw,
	input wire logic watchdog_time_sw,
	input wire logic brownout_sel,
	input wire logic watchdog_latch_sel,
	input wire logic polarity_jumper,
	input wire logic [NCH-1:0] red_fail_en_sw,
	input wire logic [NCH-1:0] dual_en_sw,
	input wire logic front_reset,
	input wire logic remote_reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic triggered,
	output logic [smf_pkg::NF-1:0] status_lamp,
	output logic [NCH-1:0] lamp_green,
	output logic [NCH-1:0] lamp_yellow,
	output logic [NCH-1:0] lamp_red
);
	localparam int TW = smf_pkg::TW;
	localparam int NF = smf_pkg::NF;
	localparam int CW = smf_pkg::CFG_W;

	// ==========================================================
	// Tick and synchronous configuration sampling
	smf_tick_if tk ();
	smf_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tk)
	);
	wire logic ms = tk.ms_tick;

	logic [CW-1:0] cfg_reg, cfg_ref_reg;
	logic ref_ok_reg;
	wire logic [CW-1:0] cfg_now = {red_fail_time_sw, watchdog_time_sw,
		brownout_sel, watchdog_latch_sel, polarity_jumper,
		red_fail_en_sw, dual_en_sw};
	wire logic rf_sel = cfg_reg[CW-1];
	wire logic wd_sel = cfg_reg[CW-2];
	wire logic bo_sel = cfg_reg[CW-3];
	wire logic wdl_sel = cfg_reg[CW-4];
	wire logic pol_sel = cfg_reg[CW-5];
	wire logic [NCH-1:0] rf_en = cfg_reg[2*NCH-1:NCH];
	wire logic [NCH-1:0] dual_en = cfg_reg[NCH-1:0];
	wire logic [TW-1:0] rf_lim = smf_pkg::smf_pick(rf_sel,
		smf_pkg::RF_ON_MS, smf_pkg::RF_OFF_MS);
	wire logic [TW-1:0] wd_lim = smf_pkg::smf_pick(wd_sel,
		smf_pkg::WD_ON_MS, smf_pkg::WD_OFF_MS);
	wire logic [TW-1:0] bo_lim = smf_pkg::smf_pick(bo_sel,
		smf_pkg::BO_ON_MS, smf_pkg::BO_OFF_MS);
	wire logic relay_active = output_relay_common ^ pol_sel;
	wire logic mon_en = red_enable & ~relay_active;
	wire logic cfg_changed = ref_ok_reg && (cfg_reg != cfg_ref_reg);

	// ==========================================================
	// Per-channel red-fail and dual indication timers
	logic [NCH-1:0] rf_hit, dual_hit;
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_ch
			logic [TW-1:0] rf_cnt_reg, du_cnt_reg;
			wire logic none = ~(green_in[gi] | yellow_in[gi] | red_in[gi]);
			wire logic dual = (green_in[gi] & yellow_in[gi]) |
				(green_in[gi] & red_in[gi]) | (yellow_in[gi] & red_in[gi]);
			wire logic rf_run = mon_en & rf_en[gi] & none;
			wire logic du_run = mon_en & dual_en[gi] & dual;
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					rf_cnt_reg <= '0;
					du_cnt_reg <= '0;
				end
				else
				begin
					if (!rf_run)
						rf_cnt_reg <= '0;
					else if (ms && !rf_hit[gi])
						rf_cnt_reg <= rf_cnt_reg + 1'b1;
					if (!du_run)
						du_cnt_reg <= '0;
					else if (ms && !dual_hit[gi])
						du_cnt_reg <= du_cnt_reg + 1'b1;
				end
			end
			assign rf_hit[gi] = rf_run && (rf_cnt_reg >= rf_lim);
			assign dual_hit[gi] = du_run && (du_cnt_reg >= smf_pkg::DUAL_MS);
		end
	endgenerate

	// ==========================================================
	// Watchdog, brown-out, front reset hold and blink timers
	logic wd_prev_reg, bo_reg, fr_prev_reg, blink_reg;
	logic [TW-1:0] wd_cnt_reg, bo_cnt_reg, fr_cnt_reg, bl_cnt_reg;
	wire logic wd_edge = watchdog_timer ^ wd_prev_reg;
	wire logic wd_hit = wd_cnt_reg >= wd_lim;
	wire logic bo_next = ac_low && (bo_cnt_reg >= bo_lim);
	wire logic power_event = bo_next & ~bo_reg;
	wire logic fr_hold_done = front_reset && ms &&
		(fr_cnt_reg == smf_pkg::CFG_HOLD_MS - 1'b1);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wd_prev_reg <= 1'b0;
			wd_cnt_reg <= '0;
			bo_cnt_reg <= '0;
			bo_reg <= 1'b0;
			fr_prev_reg <= 1'b0;
			fr_cnt_reg <= '0;
			bl_cnt_reg <= '0;
			blink_reg <= 1'b0;
		end
		else
		begin
			wd_prev_reg <= watchdog_timer;
			if (wd_edge || power_event)
				wd_cnt_reg <= '0;
			else if (ms && !wd_hit)
				wd_cnt_reg <= wd_cnt_reg + 1'b1;
			if (!ac_low)
				bo_cnt_reg <= '0;
			else if (ms && !bo_next)
				bo_cnt_reg <= bo_cnt_reg + 1'b1;
			bo_reg <= bo_next;
			fr_prev_reg <= front_reset;
			if (!front_reset)
				fr_cnt_reg <= '0;
			else if (ms && fr_cnt_reg != smf_pkg::CFG_HOLD_MS)
				fr_cnt_reg <= fr_cnt_reg + 1'b1;
			if (ms)
				bl_cnt_reg <= (bl_cnt_reg == smf_pkg::BLINK_MS - 1'b1) ?
					'0 : bl_cnt_reg + 1'b1;
			if (ms && bl_cnt_reg == smf_pkg::BLINK_MS - 1'b1)
				blink_reg <= ~blink_reg;
		end
	end

	// ==========================================================
	// APB slave decode
	logic [NF-1:0] fault_reg, irq_stat_reg, irq_mask_reg;
	logic [NCH-1:0] chan_reg;
	logic [31:0] prdata_reg;
	smf_pkg::smf_state_t state_reg, state_next;
	wire logic setup = psel & ~penable;
	wire logic access = psel & penable;
	wire logic hit_ctrl = paddr == smf_pkg::ADDR_CTRL;
	wire logic hit_stat = paddr == smf_pkg::ADDR_STATUS;
	wire logic hit_chan = paddr == smf_pkg::ADDR_CHAN;
	wire logic hit_istat = paddr == smf_pkg::ADDR_IRQ_STAT;
	wire logic hit_imask = paddr == smf_pkg::ADDR_IRQ_MASK;
	wire logic mapped = hit_ctrl | hit_stat | hit_chan | hit_istat | hit_imask;
	wire logic sw_reset = access & pwrite & hit_ctrl &
		pwdata[smf_pkg::CTRL_RESET_BIT];
	wire logic istat_rd = access & ~pwrite & hit_istat;
	wire logic [31:0] rd_mux =
		hit_ctrl ? 32'h0 :
		hit_stat ? {22'h0, fault_reg} :
		hit_chan ? {14'h0, chan_reg} :
		hit_istat ? {22'h0, irq_stat_reg} :
		hit_imask ? {22'h0, irq_mask_reg} : 32'h0;
	assign pready = access;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_reg;

	// ==========================================================
	// Fault latch
	wire logic run = state_reg == smf_pkg::SMF_RUN;
	wire logic reset_cmd = (front_reset & ~fr_prev_reg) | remote_reset |
		sw_reset;
	logic [NF-1:0] cause, clr_mask, fault_next, new_fault;
	always_comb
	begin
		cause = '0;
		cause[smf_pkg::F_DC] = dc_supply_fail;
		cause[smf_pkg::F_WD] = wd_hit;
		cause[smf_pkg::F_CONF] = conflict_in;
		cause[smf_pkg::F_RF] = |rf_hit;
		cause[smf_pkg::F_DUAL] = |dual_hit;
		cause[smf_pkg::F_CLR] = clearance_in & mon_en;
		cause[smf_pkg::F_CARD] = ~card_present;
		cause[smf_pkg::F_MON] = diag_fail;
		cause[smf_pkg::F_CFG] = cfg_changed;
		clr_mask = reset_cmd ? {NF{1'b1}} : '0;
		clr_mask[smf_pkg::F_CFG] = fr_hold_done;
		clr_mask[smf_pkg::F_CARD] = reset_cmd & card_present;
		clr_mask[smf_pkg::F_WD] = reset_cmd | (power_event & ~wdl_sel);
	end
	assign new_fault = run ? cause : '0;
	assign fault_next = (fault_reg & ~clr_mask) | new_fault;
	assign state_next = (|fault_next) ? smf_pkg::SMF_TRIG : smf_pkg::SMF_RUN;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= smf_pkg::SMF_RUN;
			fault_reg <= '0;
			chan_reg <= '0;
			cfg_reg <= '0;
			cfg_ref_reg <= '0;
			ref_ok_reg <= 1'b0;
			lamp_green <= '0;
			lamp_yellow <= '0;
			lamp_red <= '0;
		end
		else
		begin
			state_reg <= state_next;
			fault_reg <= fault_next;
			cfg_reg <= cfg_now;
			ref_ok_reg <= 1'b1;
			if (!ref_ok_reg || fr_hold_done)
				cfg_ref_reg <= ref_ok_reg ? cfg_reg : cfg_now;
			if (run && |cause)
				chan_reg <= cause[smf_pkg::F_CONF] ?
					(green_in | yellow_in | red_in) : (rf_hit | dual_hit);
			else if (state_next == smf_pkg::SMF_RUN)
				chan_reg <= '0;
			if (run)
			begin
				lamp_green <= green_in;
				lamp_yellow <= yellow_in;
				lamp_red <= red_in;
			end
		end
	end

	// ==========================================================
	// Registers, interrupt and status lamps
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata_reg <= 32'h0;
			irq_stat_reg <= '0;
			irq_mask_reg <= smf_pkg::IRQ_MASK_RST;
		end
		else
		begin
			if (setup)
				prdata_reg <= rd_mux;
			irq_stat_reg <= (irq_stat_reg &
				~(istat_rd ? prdata_reg[NF-1:0] : '0)) | new_fault;
			if (access && pwrite && hit_imask)
				irq_mask_reg <= pwdata[NF-1:0];
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign triggered = (state_reg == smf_pkg::SMF_TRIG) | bo_reg;
	always_comb
	begin
		status_lamp = fault_reg;
		status_lamp[smf_pkg::F_AC] = ~bo_reg | blink_reg;
	end

	// ==========================================================
	// Assertions
	sequence card_gone_s;
		run && !card_present;
	endsequence
	property card_trig_p;
		@(posedge clk) disable iff (!reset_n)
		card_gone_s |=> triggered && fault_reg[smf_pkg::F_CARD];
	endproperty
	card_trig_a: assert property (card_trig_p)
		else $error("Missing card did not trigger.");
	card_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		fault_reg[smf_pkg::F_CARD] && !card_present |=>
		fault_reg[smf_pkg::F_CARD])
		else $error("Card fault left while card absent.");
	lamp_freeze_a: assert property (@(posedge clk) disable iff (!reset_n)
		!run && state_next == smf_pkg::SMF_TRIG |=> $stable(lamp_red)
		&& $stable(lamp_green) && $stable(chan_reg))
		else $error("Recorded lamps changed while triggered.");
	no_new_a: assert property (@(posedge clk) disable iff (!reset_n)
		!run |=> (fault_reg & ~$past(fault_reg)) == '0)
		else $error("New fault recorded while triggered.");
	cfg_remote_a: assert property (@(posedge clk) disable iff (!reset_n)
		fault_reg[smf_pkg::F_CFG] && !front_reset |=>
		fault_reg[smf_pkg::F_CFG])
		else $error("Config fault cleared without front hold.");
	wd_power_a: assert property (@(posedge clk) disable iff (!reset_n)
		power_event && !wdl_sel && !new_fault[smf_pkg::F_WD] |=>
		!fault_reg[smf_pkg::F_WD])
		else $error("Watchdog fault survived power event.");
	wd_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
		fault_reg[smf_pkg::F_WD] && wdl_sel && !reset_cmd |=>
		fault_reg[smf_pkg::F_WD])
		else $error("Latched watchdog fault lost.");
	rf_time_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(rf_hit[3]) |-> g_ch[3].rf_cnt_reg == rf_lim)
		else $error("Red fail time wrong.");
	pol_sense_a: assert property (@(posedge clk) disable iff (!reset_n)
		red_enable && (output_relay_common == pol_sel) |-> mon_en)
		else $error("Relay common sense wrong.");
	conf_chan_a: assert property (@(posedge clk) disable iff (!reset_n)
		run && conflict_in |=> chan_reg == $past(green_in | yellow_in |
		red_in))
		else $error("Conflict channels not recorded.");
endmodule // smf_monitor
`default_nettype wire

// file: hw/smf_pkg.sv
// Constants, types and helpers shared by the signal monitor fault logic.
`default_nettype none
package smf_pkg;
	// ==========================================================
	// Sizes and timing
	localparam int NCH = 18;
	localparam int TW = 12;
	localparam int CLK_HZ = 125000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam logic [TW-1:0] RF_ON_MS = 12'd1350;
	localparam logic [TW-1:0] RF_OFF_MS = 12'd850;
	localparam logic [TW-1:0] WD_ON_MS = 12'd1000;
	localparam logic [TW-1:0] WD_OFF_MS = 12'd1500;
	localparam logic [TW-1:0] BO_ON_MS = 12'd400;
	localparam logic [TW-1:0] BO_OFF_MS = 12'd80;
	localparam logic [TW-1:0] DUAL_MS = 12'd350;
	localparam logic [TW-1:0] CFG_HOLD_MS = 12'd3000;
	localparam logic [TW-1:0] BLINK_MS = 12'd250;
	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CHAN = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam int CTRL_RESET_BIT = 0;
	localparam logic [9:0] IRQ_MASK_RST = 10'h000;
	// ==========================================================
	// Fault bit positions
	localparam int NF = 10;
	localparam int F_AC = 0;
	localparam int F_DC = 1;
	localparam int F_WD = 2;
	localparam int F_CONF = 3;
	localparam int F_RF = 4;
	localparam int F_DUAL = 5;
	localparam int F_CLR = 6;
	localparam int F_CARD = 7;
	localparam int F_MON = 8;
	localparam int F_CFG = 9;
	localparam int CFG_W = 5 + 2 * NCH;
	typedef enum logic [1:0] {
		SMF_RUN = 2'b00,
		SMF_TRIG = 2'b01
	} smf_state_t;
	// ==========================================================
	// Picks one of two times by a switch.
	function automatic logic [TW-1:0] smf_pick(input logic on_sel,
		input logic [TW-1:0] on_ms, input logic [TW-1:0] off_ms);
		return on_sel ? on_ms : off_ms;
	endfunction
endpackage
`default_nettype wire

// file: hw/smf_tick.sv
// Divider that makes a one-cycle millisecond tick from the system clock.
`default_nettype none
module smf_tick #(
	parameter int MS_CYCLES = smf_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	smf_tick_if.src tick
);
	logic [31:0] cnt_reg;
	logic tick_reg;
	wire logic wrap = (cnt_reg == 32'(MS_CYCLES - 1));

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= wrap ? 32'h0 : cnt_reg + 32'h1;
			tick_reg <= wrap;
		end
	end

	assign tick.ms_tick = tick_reg;
endmodule // smf_tick
`default_nettype wire

// file: hw/smf_tick_if.sv
// Millisecond tick carried from the divider to the monitor logic.
`default_nettype none
interface smf_tick_if;
	logic ms_tick;
	modport src (output ms_tick);
	modport dst (input ms_tick);
endinterface
`default_nettype wire

// file: test/signal_monitor_fault_control_tb.sv
// Self-checking bench of the signal monitor fault logic.
`default_nettype none
module signal_monitor_fault_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 5;
	localparam int LIMIT = 80000;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic card_present = 1'h1, conflict_in = 1'h0, ac_low = 1'h0;
	logic rf_sw = 1'h0, wd_sw = 1'h0, bo_sel = 1'h0, lt_sel = 1'h0;
	logic pol = 1'h0, front_reset = 1'h0, remote_reset = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, irq, triggered, rerr;
	logic wd_run = 1'h1, relay_hi = 1'h0, red_en, relay, wd_line;
	logic [17:0] dark_ch = 18'h0, green_ch = 18'h0;
	logic [17:0] g_in, y_in, r_in, lamp_green, lamp_yellow, lamp_red;
	logic [9:0] status_lamp;
	int num_errors = 0, cmp_count = 0, cyc = 0, bo, wt;
	always #4 clk = ~clk;
	smf_field #(.HALF(20 * MS)) field (.clk(clk), .wd_run(wd_run),
		.relay_hi(relay_hi), .dark_ch(dark_ch), .green_ch(green_ch),
		.green(g_in), .yellow(y_in), .red(r_in), .red_enable(red_en),
		.relay(relay), .wd_line(wd_line));
	smf_monitor #(.MS_CYCLES(MS)) DUT (.clk(clk), .reset_n(reset_n),
		.green_in(g_in), .yellow_in(y_in), .red_in(r_in),
		.red_enable(red_en), .output_relay_common(relay),
		.conflict_in(conflict_in), .clearance_in(1'h0),
		.dc_supply_fail(1'h0), .diag_fail(1'h0),
		.card_present(card_present), .watchdog_timer(wd_line),
		.ac_low(ac_low), .red_fail_time_sw(rf_sw),
		.watchdog_time_sw(wd_sw), .brownout_sel(bo_sel),
		.watchdog_latch_sel(lt_sel), .polarity_jumper(pol),
		.red_fail_en_sw(18'h3ffff), .dual_en_sw(18'h0),
		.front_reset(front_reset), .remote_reset(remote_reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .triggered(triggered),
		.status_lamp(status_lamp), .lamp_green(lamp_green),
		.lamp_yellow(lamp_yellow), .lamp_red(lamp_red));
	// ==========================================================
	// Report and helpers.
	task automatic summarize();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			num_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic chkt(input logic e);
		#1;
		chk({31'h0, triggered}, {31'h0, e});
		@(posedge clk);
	endtask
	task automatic wait_ms(input int n);
		repeat (n * MS) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rdata, exp);
	endtask
	task automatic do_reset(input logic rf, input logic wd,
		input logic b, input logic lt, input logic p);
		@(posedge clk);
		reset_n <= 1'h0;
		rf_sw <= rf;
		wd_sw <= wd;
		bo_sel <= b;
		lt_sel <= lt;
		pol <= p;
		repeat (3) @(posedge clk);
		chk({31'h0, status_lamp[0]}, 32'h1);
		reset_n <= 1'h1;
		repeat (3) @(posedge clk);
	endtask
	// ==========================================================
	// Test sequence.
	initial
	begin
		do_reset(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
		rchk(smf_pkg::ADDR_IRQ_MASK, 32'h0);
		rchk(8'h14, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk({14'h0, lamp_red}, 32'h3ffff);
		chk({14'h0, lamp_yellow}, 32'h0);
		dark_ch <= 18'h8;
		wait_ms(1100);
		chkt(1'h0);
		relay_hi <= 1'h1;
		wait_ms(700);
		chkt(1'h0);
		wait_ms(300);
		chkt(1'h1);
		rchk(smf_pkg::ADDR_CHAN, 32'h8);
		rchk(smf_pkg::ADDR_STATUS, 32'h10);
		relay_hi <= 1'h0;
		do_reset(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
		wait_ms(1200);
		chkt(1'h0);
		wait_ms(300);
		chkt(1'h1);
		dark_ch <= 18'h0;
		do_reset(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		apb(1'h1, smf_pkg::ADDR_IRQ_MASK, 32'h80);
		card_present <= 1'h0;
		repeat (3) @(posedge clk);
		chkt(1'h1);
		chk({31'h0, irq}, 32'h1);
		rchk(smf_pkg::ADDR_STATUS, 32'h80);
		rchk(smf_pkg::ADDR_IRQ_STAT, 32'h80);
		#1;
		chk({31'h0, irq}, 32'h0);
		@(posedge clk);
		green_ch <= 18'h5;
		conflict_in <= 1'h1;
		repeat (3) @(posedge clk);
		chk({14'h0, lamp_green}, 32'h0);
		rchk(smf_pkg::ADDR_STATUS, 32'h80);
		conflict_in <= 1'h0;
		apb(1'h1, smf_pkg::ADDR_CTRL, 32'h1);
		chkt(1'h1);
		card_present <= 1'h1;
		apb(1'h1, smf_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chkt(1'h0);
		green_ch <= 18'h21;
		dark_ch <= 18'h3ffff;
		repeat (3) @(posedge clk);
		conflict_in <= 1'h1;
		repeat (3) @(posedge clk);
		conflict_in <= 1'h0;
		chkt(1'h1);
		rchk(smf_pkg::ADDR_CHAN, 32'h21);
		rchk(smf_pkg::ADDR_STATUS, 32'h8);
		green_ch <= 18'h0;
		repeat (3) @(posedge clk);
		chk({14'h0, lamp_green}, 32'h21);
		remote_reset <= 1'h1;
		dark_ch <= 18'h0;
		@(posedge clk);
		remote_reset <= 1'h0;
		repeat (2) @(posedge clk);
		chkt(1'h0);
		for (int l = 0; l < 2; l++)
		begin
			do_reset(1'h0, l[0], l[0], l[0], 1'h0);
			bo = l ? 400 : 80;
			wt = l ? 1000 : 1500;
			ac_low <= 1'h1;
			wait_ms(bo - 60);
			ac_low <= 1'h0;
			chkt(1'h0);
			ac_low <= 1'h1;
			wait_ms(bo + 60);
			chkt(1'h1);
			ac_low <= 1'h0;
			apb(1'h1, smf_pkg::ADDR_CTRL, 32'h1);
			repeat (2) @(posedge clk);
			chkt(1'h0);
			wd_run <= 1'h0;
			wait_ms(wt - 150);
			chkt(1'h0);
			wait_ms(250);
			chkt(1'h1);
			ac_low <= 1'h1;
			wait_ms(bo + 60);
			ac_low <= 1'h0;
			wait_ms(2);
			apb(1'h0, smf_pkg::ADDR_STATUS, 32'h0);
			chk((rdata >> 2) & 32'h1, 32'(l));
			wd_run <= 1'h1;
			wait_ms(25);
		end
		apb(1'h1, smf_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		apb(1'h0, smf_pkg::ADDR_STATUS, 32'h0);
		chk(rdata & 32'h4, 32'h0);
		bo_sel <= 1'h0;
		wait_ms(2);
		apb(1'h0, smf_pkg::ADDR_STATUS, 32'h0);
		chk(rdata & 32'h200, 32'h200);
		remote_reset <= 1'h1;
		@(posedge clk);
		remote_reset <= 1'h0;
		repeat (2) @(posedge clk);
		apb(1'h0, smf_pkg::ADDR_STATUS, 32'h0);
		chk(rdata & 32'h200, 32'h200);
		front_reset <= 1'h1;
		wait_ms(1000);
		chkt(1'h1);
		wait_ms(2100);
		front_reset <= 1'h0;
		repeat (2) @(posedge clk);
		chkt(1'h0);
		summarize();
	end
endmodule // signal_monitor_fault_control_tb
`default_nettype wire

// file: test/smf_field.sv
// Model of the controller watchdog line and the cabinet field signals.
`default_nettype none
module smf_field #(
	parameter int HALF = 100
) (
	input wire logic clk,
	input wire logic wd_run,
	input wire logic relay_hi,
	input wire logic [smf_pkg::NCH-1:0] dark_ch,
	input wire logic [smf_pkg::NCH-1:0] green_ch,
	output logic [smf_pkg::NCH-1:0] green,
	output logic [smf_pkg::NCH-1:0] yellow,
	output logic [smf_pkg::NCH-1:0] red,
	output logic red_enable,
	output logic relay,
	output logic wd_line
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// ==========================================================
	// Field lines change only just after a clock edge.
	always @(posedge clk)
	begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (wd_run && cnt == HALF - 1)
			wd_line <= ~wd_line;
		if (wd_line === 1'bx)
			wd_line <= 1'h0;
		green <= green_ch;
		red <= ~(dark_ch | green_ch);
		yellow <= '0;
		red_enable <= 1'h1;
		relay <= relay_hi;
	end
endmodule // smf_field
`default_nettype wire
